// file: src/fced_pkg.sv
// constants, register map and state codes of the frame check and energy detect block
package fced_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int CLK_MHZ = 250;                            // core clock, 4 ns period
    localparam int ED_DONE_US = 140;                         // result stored this long after start
    localparam int ED_DONE_CYC = ED_DONE_US * CLK_MHZ;       // 35000 cycles
    localparam int ED_AVG_US = 128;                          // averaging window, eight symbols
    localparam int RSSI_UPD_US = 2;                          // signal-strength refresh period
    localparam int RSSI_UPD_CYC = RSSI_UPD_US * CLK_MHZ;     // 500 cycles
    localparam int ED_SAMPLES = ED_AVG_US / RSSI_UPD_US;     // 64 samples per average

    ////////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_TX_CTRL = 8'h05;              // tx_power_and_fcs_control
    localparam logic [7:0] IDX_RSSI = 8'h06;                 // signal_strength_and_fcs_status
    localparam logic [7:0] IDX_ED = 8'h07;                   // energy_level_result
    localparam logic [7:0] ADDR_TX_CTRL = {IDX_TX_CTRL[5:0], 2'b00};
    localparam logic [7:0] ADDR_RSSI = {IDX_RSSI[5:0], 2'b00};
    localparam logic [7:0] ADDR_ED = {IDX_ED[5:0], 2'b00};

    ////////////////////////////////////////////////////////////////////////////
    // fields and reset values
    localparam int AUTO_CRC_POS = 7;                         // auto-append enable
    localparam int TXPWR_W = 4;                              // tx_power_level width
    localparam int CRC_VALID_POS = 7;                        // receive check result
    localparam int RSSI_W = 5;                               // signal-strength field width
    localparam logic [7:0] TX_CTRL_RST = 8'h00;
    localparam logic [7:0] ED_RST = 8'h00;
    localparam logic [7:0] ED_MAX = 8'h54;                   // 84 dB top code
    localparam logic [4:0] RSSI_MAX = 5'h1C;                 // 28, top signal-strength code

    ////////////////////////////////////////////////////////////////////////////
    // check value and frame lengths
    localparam int CRC_W = 16;
    localparam logic [15:0] CRC_POLY = 16'h1021;             // x^16 + x^12 + x^5 + 1
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [6:0] LEN_MIN_AUTO = 7'h03;
    localparam logic [6:0] LEN_MIN_CHECK = 7'h02;
    localparam logic [6:0] FCS_BYTES = 7'h02;

    ////////////////////////////////////////////////////////////////////////////
    // state codes, gray along the usual transmit path; receive steps from RX_EVAL 2'b11 back to RX_IDLE 2'b00
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_BODY = 2'b01,
        TX_FCS_LO = 2'b11,
        TX_FCS_HI = 2'b10
    } fced_tx_st_type;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_BODY = 2'b01,
        RX_EVAL = 2'b11
    } fced_rx_st_type;

    typedef enum logic {
        ED_IDLE = 1'b0,
        ED_RUN = 1'b1
    } fced_ed_st_type;

endpackage : fced_pkg

// file: src/fced_crc_if.sv
// carrier between the frame logic and one check-value engine
`timescale 1ns/1ns
interface fced_crc_if import fced_pkg::*; ();
    logic clear;                 // restart the remainder
    logic load;                  // fold one byte in
    logic [7:0] data;            // byte, bit 0 first on air
    logic [CRC_W-1:0] value;     // running remainder

    modport owner (output clear, output load, output data, input value);
    modport engine (input clear, input load, input data, output value);
endinterface : fced_crc_if

// file: src/fced_crc16.sv
// bytewise remainder engine for the 16-bit frame check value
`timescale 1ns/1ns
module fced_crc16 import fced_pkg::*; #(
    parameter logic [CRC_W-1:0] POLY = CRC_POLY
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    fced_crc_if.engine crc
);

    typedef struct packed {
        logic [CRC_W-1:0] rem;   // remainder, msb is r0
    } fced_crc_state_type;

    fced_crc_state_type s_q;
    fced_crc_state_type s_d;

    // eight serial division steps, bit 0 of the byte goes first
    function automatic logic [CRC_W-1:0] div_byte(input logic [CRC_W-1:0] c, input logic [7:0] b);
        logic [CRC_W-1:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = b[i] ^ r[CRC_W-1];
            r = {r[CRC_W-2:0], 1'b0};
            if (fb) begin
                r = r ^ POLY;
            end
        end
        return r;
    endfunction : div_byte

    ////////////////////////////////////////////////////////////////////////////
    // next remainder; clear wins over load
    always_comb begin
        s_d = s_q;
        if (crc.clear) begin
            s_d.rem = CRC_INIT;
        end else if (crc.load) begin
            s_d.rem = div_byte(s_q.rem, crc.data);
        end
    end

    // register the remainder
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign crc.value = s_q.rem;

endmodule : fced_crc16

// file: src/fced_top.sv
// frame check sequence generation and check, signal-strength sampling and energy detection
`timescale 1ns/1ns
module fced_top import fced_pkg::*; #(
    parameter int ED_DONE_CYC_P = ED_DONE_CYC,       // shorten for simulation
    parameter int RSSI_UPD_CYC_P = RSSI_UPD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic tx_start_i,
    input wire logic [7:0] tx_len_i,
    input wire logic tx_ack_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_byte_valid_i,
    output logic [7:0] tx_byte_o,
    output logic tx_byte_valid_o,
    output logic tx_done_o,
    input wire logic rx_start_i,
    input wire logic [7:0] rx_len_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_byte_valid_i,
    input wire logic rx_auto_ack_state_i,
    input wire logic tx_auto_retry_state_i,
    output logic frame_done_irq_o,
    output logic ack_accepted_o,
    output logic frame_dropped_o,
    input wire logic rx_state_i,
    input wire logic sfd_i,
    input wire logic [RSSI_W-1:0] rssi_i,
    output logic [TXPWR_W-1:0] tx_power_level_o
);

    localparam int UW = $clog2(RSSI_UPD_CYC_P + 1);                  // refresh timer width
    localparam int EW = $clog2(ED_DONE_CYC_P + 1);                   // measurement timer width
    localparam int SW = $clog2(ED_SAMPLES * int'(RSSI_MAX) + 1);      // sample sum width
    localparam int SH = $clog2(ED_SAMPLES);                          // divide by sample count
    localparam int NW = $clog2(ED_SAMPLES + 1);                      // sample counter width

    typedef struct packed {
        logic [31:0] prdata;             // bus read data
        logic pready;                    // bus completion
        logic pslverr;                   // unmapped address
        logic auto_crc;                  // auto-append enable
        logic [TXPWR_W-1:0] txpwr;       // tx_power_level
        fced_tx_st_type tx_st;           // transmit sequencer
        logic tx_auto;                   // this frame gets a generated value
        logic [6:0] tx_nbody;            // bytes taken from the source
        logic [6:0] tx_cnt;              // bytes passed so far
        logic [7:0] tx_byte;             // outgoing byte
        logic tx_bval;                   // outgoing byte strobe
        logic tx_done;                   // frame fully sent
        fced_rx_st_type rx_st;           // receive sequencer
        logic [6:0] rx_len;              // N of the frame
        logic [6:0] rx_cnt;              // bytes folded in
        logic rx_auto_ack_state;                   // auto-ack state latched
        logic rx_aret;                   // auto-retry state latched
        logic crc_valid;                 // receive check result
        logic irq;                       // frame_done_irq pulse
        logic ack_ok;                    // acknowledgement accepted pulse
        logic drop;                      // frame discarded pulse
        logic [RSSI_W-1:0] rssi;         // current sample
        logic [UW-1:0] rssi_tmr;         // refresh timer
        fced_ed_st_type ed_st;           // measurement running
        logic [EW-1:0] ed_tmr;           // time since start
        logic [SW-1:0] ed_sum;           // sum of samples
        logic [NW-1:0] ed_nsamp;         // samples taken
        logic [7:0] ed_lvl;              // energy_level
    } fced_state_type;

    fced_state_type s;
    fced_state_type n;
    logic [1:0] rst_sync_q;              // reset release pipeline
    logic rst_b;                         // synchronised reset

    fced_crc_if txc ();
    fced_crc_if rxc ();

    // bit 0 of a byte leaves first, so r0 lands in the byte lsb
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction : rev8

    ////////////////////////////////////////////////////////////////////////////
    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // one engine per direction, so an acknowledgement can go out right after a reception
    fced_crc16 u_tx_crc (.clk_i(clk_i), .rst_b_i(rst_b), .ce_i(ce_i), .crc(txc.engine));
    fced_crc16 u_rx_crc (.clk_i(clk_i), .rst_b_i(rst_b), .ce_i(ce_i), .crc(rxc.engine));

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic for bus, transmit, receive and energy paths
    always_comb begin
        logic acc;
        logic hit;
        logic ed_start;
        logic tick;
        logic aut;
        logic chk;
        logic [6:0] len;
        logic [6:0] nb;
        logic [31:0] rd;
        logic [SW+1:0] sc;
        acc = psel_i & penable_i;
        hit = (paddr_i == ADDR_TX_CTRL) || (paddr_i == ADDR_RSSI) || (paddr_i == ADDR_ED);
        ed_start = 1'b0;
        tick = 1'b0;
        aut = 1'b0;
        chk = 1'b0;
        len = '0;
        nb = '0;
        rd = '0;
        sc = '0;
        n = s;
        n.tx_bval = 1'b0;
        n.tx_done = 1'b0;
        n.irq = 1'b0;
        n.ack_ok = 1'b0;
        n.drop = 1'b0;
        txc.clear = 1'b0;
        txc.load = 1'b0;
        txc.data = tx_byte_i;
        rxc.clear = 1'b0;
        rxc.load = 1'b0;
        rxc.data = rx_byte_i;

        // read mux; reserved bits read zero
        unique case (paddr_i)
            ADDR_TX_CTRL: rd[7:0] = {s.auto_crc, 3'b000, s.txpwr};
            ADDR_RSSI: rd[7:0] = {s.crc_valid, 2'b00, s.rssi};
            ADDR_ED: rd[7:0] = rx_state_i ? s.ed_lvl : ED_RST;
            default: rd = '0;
        endcase

        // one wait state: answer on the cycle after the access phase opens
        n.pready = acc & !s.pready;
        n.pslverr = acc & !s.pready & !hit;
        if (acc && !s.pready) begin
            n.prdata = rd;
        end
        if (acc && s.pready && pwrite_i && !s.pslverr) begin
            if (paddr_i == ADDR_TX_CTRL) begin
                n.auto_crc = pwdata_i[AUTO_CRC_POS];
                n.txpwr = pwdata_i[TXPWR_W-1:0];
            end
            if (paddr_i == ADDR_ED) begin
                ed_start = 1'b1;
            end
        end

        // transmit: pass the body, then emit the remainder
        unique case (s.tx_st)
            TX_IDLE: begin
                if (tx_start_i) begin
                    len = tx_len_i[6:0];
                    aut = (s.auto_crc | tx_ack_i) & (len >= LEN_MIN_AUTO);
                    nb = aut ? 7'(len - FCS_BYTES) : len;
                    n.tx_auto = aut;
                    n.tx_nbody = nb;
                    n.tx_cnt = '0;
                    txc.clear = 1'b1;
                    n.tx_st = (nb == 7'h00) ? TX_IDLE : TX_BODY;
                    n.tx_done = (nb == 7'h00);
                end
            end
            TX_BODY: begin
                if (tx_byte_valid_i) begin
                    n.tx_byte = tx_byte_i;
                    n.tx_bval = 1'b1;
                    txc.load = 1'b1;
                    n.tx_cnt = 7'(s.tx_cnt + 7'h01);
                    if (n.tx_cnt == s.tx_nbody) begin
                        n.tx_st = s.tx_auto ? TX_FCS_LO : TX_IDLE;
                        n.tx_done = !s.tx_auto;
                    end
                end
            end
            TX_FCS_LO: begin
                // source bytes here are dummies and are not used
                n.tx_byte = rev8(txc.value[15:8]);
                n.tx_bval = 1'b1;
                n.tx_st = TX_FCS_HI;
            end
            TX_FCS_HI: begin
                n.tx_byte = rev8(txc.value[7:0]);
                n.tx_bval = 1'b1;
                n.tx_done = 1'b1;
                n.tx_st = TX_IDLE;
            end
        endcase

        // receive: fold every byte incl. the footer, remainder zero means intact
        unique case (s.rx_st)
            RX_IDLE: begin
                if (rx_start_i) begin
                    n.rx_len = rx_len_i[6:0];
                    n.rx_cnt = '0;
                    n.rx_auto_ack_state = rx_auto_ack_state_i;
                    n.rx_aret = tx_auto_retry_state_i;
                    rxc.clear = 1'b1;
                    n.rx_st = (rx_len_i[6:0] == 7'h00) ? RX_EVAL : RX_BODY;
                end
            end
            RX_BODY: begin
                if (rx_byte_valid_i) begin
                    rxc.load = 1'b1;
                    n.rx_cnt = 7'(s.rx_cnt + 7'h01);
                    if (n.rx_cnt == s.rx_len) begin
                        n.rx_st = RX_EVAL;
                    end
                end
            end
            RX_EVAL: begin
                chk = (s.rx_len >= LEN_MIN_CHECK) && (rxc.value == CRC_INIT);
                if (s.rx_aret) begin
                    n.ack_ok = chk;
                end else if (s.rx_auto_ack_state && !chk) begin
                    n.drop = 1'b1;
                end else begin
                    n.irq = 1'b1;
                    if (s.rx_len >= LEN_MIN_CHECK) begin
                        n.crc_valid = chk;
                    end
                end
                n.rx_st = RX_IDLE;
            end
            default: n.rx_st = RX_IDLE;
        endcase

        // signal-strength refresh while receiving; out-of-range samples clipped
        if (rx_state_i) begin
            if (s.rssi_tmr == UW'(RSSI_UPD_CYC_P - 1)) begin
                n.rssi_tmr = '0;
                n.rssi = (rssi_i > RSSI_MAX) ? RSSI_MAX : rssi_i;
                tick = 1'b1;
            end else begin
                n.rssi_tmr = UW'(s.rssi_tmr + 1'b1);
            end
        end else begin
            n.rssi_tmr = '0;
        end

        // energy measurement; old level stays readable until the new one lands
        if (sfd_i || ed_start) begin
            n.ed_st = ED_RUN;
            n.ed_tmr = '0;
            n.ed_sum = '0;
            n.ed_nsamp = '0;
        end else if (s.ed_st == ED_RUN) begin
            if (tick && (s.ed_nsamp < NW'(ED_SAMPLES))) begin
                n.ed_sum = SW'(s.ed_sum + SW'(n.rssi));
                n.ed_nsamp = NW'(s.ed_nsamp + 1'b1);
            end
            if (s.ed_tmr == EW'(ED_DONE_CYC_P - 1)) begin
                sc = (SW+2)'({2'b00, s.ed_sum} + {1'b0, s.ed_sum, 1'b0});
                n.ed_lvl = 8'(sc >> SH);
                if (n.ed_lvl > ED_MAX) begin
                    n.ed_lvl = ED_MAX;
                end
                n.ed_st = ED_IDLE;
            end else begin
                n.ed_tmr = EW'(s.ed_tmr + 1'b1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.auto_crc <= TX_CTRL_RST[AUTO_CRC_POS];
            s.txpwr <= TX_CTRL_RST[TXPWR_W-1:0];
            s.ed_lvl <= ED_RST;
        end else if (ce_i) begin
            s <= n;
        end
    end

    assign prdata_o = s.prdata;
    assign pready_o = s.pready;
    assign pslverr_o = s.pslverr;
    assign tx_power_level_o = s.txpwr;
    assign tx_byte_o = s.tx_byte;
    assign tx_byte_valid_o = s.tx_bval;
    assign tx_done_o = s.tx_done;
    assign frame_done_irq_o = s.irq;
    assign ack_accepted_o = s.ack_ok;
    assign frame_dropped_o = s.drop;

    ////////////////////////////////////////////////////////////////////////////
    // checks on the logic above
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b);

    property p_clear_on_start;
        ce_i && s.tx_st == TX_IDLE && tx_start_i |=> txc.value == CRC_INIT;
    endproperty
    a_clear_on_start: assert property (p_clear_on_start) else $error("remainder not cleared");

    property p_no_auto;
        ce_i && s.tx_st == TX_IDLE && tx_start_i && !s.auto_crc && !tx_ack_i |=> !s.tx_auto;
    endproperty
    a_no_auto: assert property (p_no_auto) else $error("append without enable");

    property p_ack_gets_fcs;
        ce_i && s.tx_st == TX_IDLE && tx_start_i && tx_ack_i && tx_len_i[6:0] >= LEN_MIN_AUTO
            |=> s.tx_auto && s.tx_nbody == 7'($past(tx_len_i[6:0]) - FCS_BYTES);
    endproperty
    a_ack_gets_fcs: assert property (p_ack_gets_fcs) else $error("ack lacks check value");

    property p_fcs_order;
        ce_i && s.tx_st == TX_FCS_LO ##1 ce_i
            |-> tx_byte_valid_o && tx_byte_o == rev8($past(txc.value[15:8]))
                ##1 tx_byte_valid_o && tx_done_o && tx_byte_o == rev8($past(txc.value[7:0], 2));
    endproperty
    a_fcs_order: assert property (p_fcs_order) else $error("footer bytes wrong");

    property p_rx_result;
        ce_i && s.rx_st == RX_EVAL && !s.rx_aret && !s.rx_auto_ack_state && s.rx_len >= LEN_MIN_CHECK
            |=> frame_done_irq_o && (s.crc_valid == ($past(rxc.value) == CRC_INIT));
    endproperty
    a_rx_result: assert property (p_rx_result) else $error("check result wrong");

    property p_result_held;
        !(ce_i && s.rx_st == RX_EVAL) |=> $stable(s.crc_valid);
    endproperty
    a_result_held: assert property (p_result_held) else $error("check result changed");

    property p_aack_drop;
        ce_i && s.rx_st == RX_EVAL && s.rx_auto_ack_state && !s.rx_aret && rxc.value != CRC_INIT
            |=> frame_dropped_o && !frame_done_irq_o;
    endproperty
    a_aack_drop: assert property (p_aack_drop) else $error("bad frame raised done");

    property p_aret_reject;
        ce_i && s.rx_st == RX_EVAL && s.rx_aret && rxc.value != CRC_INIT |=> !ack_accepted_o;
    endproperty
    a_aret_reject: assert property (p_aret_reject) else $error("bad ack accepted");

    property p_ed_zero;
        ce_i && psel_i && penable_i && !pready_o && paddr_i == ADDR_ED && !rx_state_i |=> prdata_o == 32'h0;
    endproperty
    a_ed_zero: assert property (p_ed_zero) else $error("energy read nonzero outside receive");

    property p_ed_range;
        s.ed_lvl <= ED_MAX;
    endproperty
    a_ed_range: assert property (p_ed_range) else $error("energy code out of range");

    property p_ed_start;
        ce_i && sfd_i |=> s.ed_st == ED_RUN && s.ed_tmr == '0 && $stable(s.ed_lvl);
    endproperty
    a_ed_start: assert property (p_ed_start) else $error("delimiter did not start measure");

    c_tx_auto: cover property (ce_i && s.tx_st == TX_FCS_HI);
    c_rx_ok: cover property (frame_done_irq_o && s.crc_valid);
    c_drop: cover property (frame_dropped_o);
    c_ed_done: cover property (ce_i && s.ed_st == ED_RUN && s.ed_tmr == EW'(ED_DONE_CYC_P - 1));

endmodule : fced_top

// file: bench/fced_host_model.sv
// host side model: APB master that reaches the block's registers
`timescale 1ns/1ns
module fced_host_model (
    input wire logic clk_i,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o
);
    // bus idle from time zero
    initial begin
        {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
    end
    // one transfer, entered just after an edge; request held until pready is seen
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] r);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do @(posedge clk_i); while (pready_i !== 1'b1);
        r = {pslverr_i, prdata_i};
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // one idle edge, so a following call never re-drives psel in this time step
        @(posedge clk_i);
    endtask : xfer
endmodule : fced_host_model

// file: bench/fced_top_tb.sv
// self-checking bench: registers, check value on both paths, energy level
`timescale 1ns/1ns
module fced_top_tb import fced_pkg::*;;
    logic clk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1, tx_start_i = 1'b0, tx_ack_i = 1'b0, tx_byte_valid_i = 1'b0;
    logic rx_start_i = 1'b0, rx_byte_valid_i = 1'b0, rx_auto_ack_state_i = 1'b0, tx_auto_retry_state_i = 1'b0;
    logic rx_state_i = 1'b1, sfd_i = 1'b0;
    logic [7:0] tx_len_i = 8'h00, tx_byte_i = 8'h00, rx_len_i = 8'h00, rx_byte_i = 8'h00, paddr_i, tx_byte_o;
    logic [4:0] rssi_i = 5'h1C;
    logic [31:0] pwdata_i, prdata_o;
    logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, tx_byte_valid_o, tx_done_o;
    logic frame_done_irq_o, ack_accepted_o, frame_dropped_o;
    logic [3:0] tx_power_level_o;
    logic [32:0] r;
    logic [7:0] q[$];
    int err_count = 0, n_compared = 0, cyc = 0, n_irq = 0, n_ack = 0, n_drop = 0, n_done = 0;
    // short energy counts keep the run brief
    fced_top #(.ED_DONE_CYC_P(400), .RSSI_UPD_CYC_P(5)) u_fced_top (.clk_i, .rst_b_i, .ce_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .tx_start_i, .tx_len_i, .tx_ack_i,
        .tx_byte_i, .tx_byte_valid_i, .tx_byte_o, .tx_byte_valid_o, .tx_done_o, .rx_start_i, .rx_len_i, .rx_byte_i,
        .rx_byte_valid_i, .rx_auto_ack_state_i, .tx_auto_retry_state_i, .frame_done_irq_o, .ack_accepted_o,
        .frame_dropped_o, .rx_state_i, .sfd_i, .rssi_i, .tx_power_level_o);
    fced_host_model u_fced_host_model (.clk_i, .prdata_i(prdata_o), .pready_i(pready_o), .pslverr_i(pslverr_o),
        .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // collect outgoing bytes and events; cut a hang short
    always @(posedge clk_i) begin
        if (tx_byte_valid_o === 1'b1) q.push_back(tx_byte_o);
        if (frame_done_irq_o === 1'b1) n_irq++;
        if (ack_accepted_o === 1'b1) n_ack++;
        if (frame_dropped_o === 1'b1) n_drop++;
        if (tx_done_o === 1'b1) n_done++;
        if (++cyc == 4000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic chk(input logic [32:0] s, input logic [32:0] e);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        u_fced_host_model.xfer(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask : rd
    // one frame out; body bytes back to back, then compare what left
    task automatic tx(input logic [7:0] n, input logic [7:0] b[$], input logic [7:0] e[$]);
        q.delete();
        n_done = 0;
        tx_start_i <= 1'b1;
        tx_len_i <= n;
        @(posedge clk_i);
        tx_start_i <= 1'b0;
        foreach (b[i]) begin
            tx_byte_i <= b[i];
            tx_byte_valid_i <= 1'b1;
            @(posedge clk_i);
        end
        tx_byte_valid_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(q.size(), e.size());
        foreach (e[i]) chk(q[i], e[i]);
        chk(n_done, 1);
    endtask : tx
    // one frame in, reserved length bit set; expect at most one event, as weighed by ev, and the status word
    // ev weighs the events seen: done 4, ack accepted 2, dropped 1
    task automatic rx(input logic [7:0] b[$], input logic [32:0] e, input int ev = 4);
        n_irq = 0;
        n_ack = 0;
        n_drop = 0;
        rx_start_i <= 1'b1;
        rx_len_i <= 8'h80 | 8'(b.size());
        @(posedge clk_i);
        rx_start_i <= 1'b0;
        foreach (b[i]) begin
            rx_byte_i <= b[i];
            rx_byte_valid_i <= 1'b1;
            @(posedge clk_i);
        end
        rx_byte_valid_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(n_irq * 4 + n_ack * 2 + n_drop, ev);
        rd(ADDR_RSSI, e);
    endtask : rx
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(ADDR_TX_CTRL, 33'h0);
        rd(ADDR_ED, 33'h0);
        rd(8'h20, 33'h1_0000_0000);
        u_fced_host_model.xfer(1'b1, ADDR_TX_CTRL, 32'hFA, r);
        rd(ADDR_TX_CTRL, 33'h8A);
        chk(tx_power_level_o, 4'hA);
        $display("test registers done");
        tx(8'h85, '{8'h02, 8'h00, 8'h6A}, '{8'h02, 8'h00, 8'h6A, 8'hE4, 8'h79});
        u_fced_host_model.xfer(1'b1, ADDR_TX_CTRL, 32'h0A, r);
        tx(8'h05, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55}, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55});
        tx_ack_i <= 1'b1;
        tx(8'h05, '{8'h02, 8'h00, 8'h6A}, '{8'h02, 8'h00, 8'h6A, 8'hE4, 8'h79});
        tx_ack_i <= 1'b0;
        $display("test transmit done");
        rx('{8'h02, 8'h00, 8'h6B, 8'hE4, 8'h79}, 33'h1C);
        rx('{8'h02, 8'h00, 8'h6A, 8'hE4, 8'h79}, 33'h9C);
        rx('{8'h55}, 33'h9C);
        rx_auto_ack_state_i <= 1'b1;
        rx('{8'h02, 8'h00, 8'h6B, 8'hE4, 8'h79}, 33'h9C, 1);
        rx_auto_ack_state_i <= 1'b0;
        tx_auto_retry_state_i <= 1'b1;
        rx('{8'h02, 8'h00, 8'h6A, 8'hE4, 8'h79}, 33'h9C, 2);
        rx('{8'h02, 8'h00, 8'h6B, 8'hE4, 8'h79}, 33'h9C, 0);
        tx_auto_retry_state_i <= 1'b0;
        $display("test receive done");
        u_fced_host_model.xfer(1'b1, ADDR_ED, 32'h0, r);
        repeat (420) @(posedge clk_i);
        rd(ADDR_ED, 33'h54);
        rssi_i <= 5'h0A;
        sfd_i <= 1'b1;
        @(posedge clk_i);
        sfd_i <= 1'b0;
        repeat (420) @(posedge clk_i);
        rd(ADDR_ED, 33'h1E);
        rx_state_i <= 1'b0;
        @(posedge clk_i);
        rd(ADDR_ED, 33'h0);
        $display("test energy done");
        end_of_test();
    end
endmodule : fced_top_tb
